// ===== rtl/bank_addr_gen.sv
// Forms the 12-bit data address of a file operand.
// Assumes a 4-bit bank pointer and an access bank split at 0x60.
`timescale 1ns/1ps
`include "bcbn_exec_defs.svh"
module bank_addr_gen (
   // Operand
   input  wire logic [7:0]  fileAddr,
   input  wire logic        useBank,
   // Bank pointer
   input  wire logic [3:0]  bankPtr,
   // Result
   output logic      [11:0] dataAddr
);
   // ==========================================================
   // Address forming
   // Access bank maps 0x00..0x5F to bank 0, 0x60..0xFF to bank 15
   always_comb begin
      if (useBank) begin
         dataAddr = {bankPtr, fileAddr};
      end else if (fileAddr < `ACCESS_SPLIT) begin
         dataAddr = {4'h0, fileAddr};
      end else begin
         dataAddr = {`ACCESS_HI_BANK, fileAddr};
      end
   end
endmodule // bank_addr_gen

// ===== rtl/bcbn_exec.sv
// Execution unit for the bit-clear and branch-if-negative instructions.
// Assumes the core presents one instruction a cycle with its address,
// gives a read port into the register file, and obeys the flush output.
// How it works
// - Bit clear zeroes one bit, keeps others
// - Operands: 8-bit file, 3-bit bit, flag
// - Branch only when negative flag is one
// - Target is address plus 2 plus 2n
`timescale 1ns/1ps
`include "bcbn_exec_defs.svh"
module bcbn_exec #(
   parameter int PC_W = 21            // Byte address width of the program counter
) (
   // Clock and reset
   input  wire logic            clock,
   input  wire logic            rstn,
   // Instruction in
   input  wire logic            instrValid,
   input  wire logic [15:0]     instrWord,
   input  wire logic [PC_W-1:0] instrAddr,
   // Core state
   input  wire logic [7:0]      statusIn,
   input  wire logic [3:0]      bankSelectPointer,
   // Register file read
   output logic      [11:0]     rdAddr,
   input  wire logic [7:0]      rdData,
   // Register file write
   output logic                 wrEn_q,
   output logic      [11:0]     wrAddr_q,
   output logic      [7:0]      wrData_q,
   // Program counter
   output logic                 pcLoad_q,
   output logic      [PC_W-1:0] pcNext_q,
   // Pipeline control
   output logic                 flush_q,
   output logic                 busy_q
);
   // ==========================================================
   // Decode
   logic            isBitClear;   // bit_clear_instr present
   logic            isBranchNeg;  // branch_if_negative_instr present
   logic [7:0]      fileAddr;     // Register operand, 0..255
   logic [2:0]      bitSel;       // Bit position, 0..7
   logic            useBank;      // 1 selects bank pointer, 0 access bank
   logic [7:0]      offset;       // Signed word offset
   logic [11:0]     dataAddr;     // Resolved data address
   logic [PC_W-1:0] target;       // Branch destination
   logic [7:0]      keepMask;     // Ones everywhere except the selected bit

   bcbn_exec_pkg::phase_t phase_q, phase_d;

   // Sign extension needs room above the doubled offset; beyond 32 is never wanted
   if (PC_W < 10 || PC_W > 32) begin : g_pc_w_check
      $error("bcbn_exec: PC_W must lie between 10 and 32");
   end

   // Field extraction; widths carry the legal operand ranges
   always_comb begin
      isBitClear  = instrValid && (phase_q == bcbn_exec_pkg::PH_EXEC)
                    && (instrWord[15:12] == `BCLR_OPC);
      isBranchNeg = instrValid && (phase_q == bcbn_exec_pkg::PH_EXEC)
                    && (instrWord[15:8] == `BNEG_OPC);
      fileAddr    = instrWord[`FLD_F_LSB +: 8];
      bitSel      = instrWord[`FLD_B_LSB +: 3];
      useBank     = instrWord[`FLD_A_POS];
      offset      = instrWord[7:0];
      // Sign-extend, double, add to the following address
      target      = instrAddr + PC_W'(`PC_STEP) + {{(PC_W-9){offset[7]}}, offset, 1'b0};
   end

   // One comparator per bit; the mask keeps every bit but the selected one
   for (genvar i = 0; i < 8; i++) begin : g_keep
      assign keepMask[i] = (bitSel != 3'(i));
   end

   bank_addr_gen uAddr (
      .fileAddr (fileAddr),
      .useBank  (useBank),
      .bankPtr  (bankSelectPointer),
      .dataAddr (dataAddr)
   );

   // Read side goes straight to the register file for same-cycle data
   assign rdAddr = dataAddr;

   // ==========================================================
   // Next-state logic
   logic            wrEn_d;
   logic [11:0]     wrAddr_d;
   logic [7:0]      wrData_d;
   logic            pcLoad_d;
   logic [PC_W-1:0] pcNext_d;
   logic            flush_d;
   logic            busy_d;       // High for the flush slot only

   // Status is only read here, never written, so no flag can move
   always_comb begin
      phase_d  = bcbn_exec_pkg::PH_EXEC;
      wrEn_d   = 1'b0;
      wrAddr_d = dataAddr;
      wrData_d = rdData;
      pcLoad_d = 1'b0;
      pcNext_d = target;
      flush_d  = 1'b0;
      busy_d   = 1'b0;
      case (phase_q)
         bcbn_exec_pkg::PH_EXEC: begin
            if (isBitClear) begin
               // Clear only the selected bit
               wrEn_d   = 1'b1;
               wrData_d = rdData & keepMask;
            end else if (isBranchNeg && statusIn[`STAT_NEG_POS]) begin
               // Taken: load PC, then one flush cycle
               pcLoad_d = 1'b1;
               flush_d  = 1'b1;
               busy_d   = 1'b1;
               phase_d  = bcbn_exec_pkg::PH_FLUSH;
            end
            // Untaken branch: nothing, sequential fetch continues
         end
         bcbn_exec_pkg::PH_FLUSH: begin
            // Second cycle is a no-operation
            phase_d = bcbn_exec_pkg::PH_EXEC;
         end
         default: begin
            phase_d = bcbn_exec_pkg::PH_EXEC;
         end
      endcase
   end

   // ==========================================================
   // Registers
   // Only the next values are stored here; all deciding is done above
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         phase_q  <= bcbn_exec_pkg::PH_EXEC;
         wrEn_q   <= 1'b0;
         wrAddr_q <= 12'h000;
         wrData_q <= 8'h00;
         pcLoad_q <= 1'b0;
         pcNext_q <= PC_W'(`PC_RST);
         flush_q  <= 1'b0;
         busy_q   <= 1'b0;
      end else begin
         phase_q  <= phase_d;
         wrEn_q   <= wrEn_d;
         wrAddr_q <= wrAddr_d;
         wrData_q <= wrData_d;
         pcLoad_q <= pcLoad_d;
         pcNext_q <= pcNext_d;
         flush_q  <= flush_d;
         busy_q   <= busy_d;
      end
   end

   // ==========================================================
   // Assertions
   // Taken branch: decoded in the execute phase with the negative flag set
   sequence s_taken;
      isBranchNeg && statusIn[`STAT_NEG_POS];
   endsequence

   // Untaken branch: decoded with the negative flag clear
   sequence s_untaken;
      isBranchNeg && !statusIn[`STAT_NEG_POS];
   endsequence

   // Answer cycle of a taken branch: load, flush and busy stand together
   sequence s_flush_pulse;
      pcLoad_q && flush_q && busy_q && !wrEn_q;
   endsequence

   // Flush slot has passed: every strobe is low again
   sequence s_all_quiet;
      !pcLoad_q && !flush_q && !busy_q && !wrEn_q;
   endsequence

   // Only the selected bit drops; the write fires one cycle after decode
   a_clear_bit: assert property (@(posedge clock) disable iff (!rstn)
      isBitClear |=> wrEn_q && wrData_q == ($past(rdData) & ~(8'h01 << $past(bitSel))))
      else $error("bit clear result wrong");

   // Banked operand takes its upper nibble from the bank pointer
   a_clear_addr: assert property (@(posedge clock) disable iff (!rstn)
      isBitClear && useBank |=> wrAddr_q == {$past(bankSelectPointer), $past(fileAddr)})
      else $error("banked address wrong");

   // Access bank splits the operand range between bank 0 and the top bank
   a_clear_access: assert property (@(posedge clock) disable iff (!rstn)
      isBitClear && !useBank |=> wrAddr_q[7:0] == $past(fileAddr)
         && wrAddr_q[11:8] == (($past(fileAddr) < `ACCESS_SPLIT) ? 4'h0 : `ACCESS_HI_BANK))
      else $error("access bank address wrong");

   // A program counter load always traces back to a taken branch
   a_taken_only: assert property (@(posedge clock) disable iff (!rstn)
      pcLoad_q |-> $past(isBranchNeg) && $past(statusIn[`STAT_NEG_POS]))
      else $error("branch load without negative");

   // A clear negative flag leaves the program counter and pipeline alone
   a_untaken_quiet: assert property (@(posedge clock) disable iff (!rstn)
      s_untaken |=> !pcLoad_q && !flush_q && !busy_q)
      else $error("untaken branch disturbed the pipeline");

   // Target counts from the following word, offset doubled after sign extension
   a_branch_target: assert property (@(posedge clock) disable iff (!rstn)
      s_taken |=> pcNext_q == $past(instrAddr) + PC_W'(2)
         + {{(PC_W-9){$past(offset[7])}}, $past(offset), 1'b0})
      else $error("branch target wrong");

   // Taken branch costs exactly two cycles, the second one idle
   a_flush_once: assert property (@(posedge clock) disable iff (!rstn)
      s_taken |=> s_flush_pulse ##1 s_all_quiet)
      else $error("flush sequence wrong");

   // Whatever arrives in the flush slot is dropped without effect
   a_flush_refuse: assert property (@(posedge clock) disable iff (!rstn)
      phase_q == bcbn_exec_pkg::PH_FLUSH |=> !wrEn_q && !pcLoad_q)
      else $error("instruction in flush slot took effect");

   // Bit clear is a single-cycle instruction: no flush behind it
   a_clear_single: assert property (@(posedge clock) disable iff (!rstn)
      isBitClear |=> !pcLoad_q && !flush_q && !busy_q)
      else $error("bit clear stalled the pipeline");
endmodule // bcbn_exec

// ===== rtl/bcbn_exec_defs.svh
// Constants for the bit-clear / branch-if-negative execution unit.
// Assumes a 21-bit byte program counter and a 16-bit instruction word.
`ifndef BCBN_EXEC_DEFS_SVH
`define BCBN_EXEC_DEFS_SVH
// Opcode fields
`define BCLR_OPC       4'h9
`define BNEG_OPC       8'he6
// Field positions in the instruction word
`define FLD_A_POS      8
`define FLD_B_LSB      9
`define FLD_F_LSB      0
// Status layout: negative flag position
`define STAT_NEG_POS   4
// Step of the program counter per instruction word
`define PC_STEP        21'h000002
// Reset value and access bank layout
`define PC_RST         21'h000000
`define ACCESS_HI_BANK 4'hf
`define ACCESS_SPLIT   8'h60
`endif

// ===== rtl/bcbn_exec_pkg.sv
// Types for the bit-clear / branch-if-negative execution unit.
// Assumes nothing of its surroundings.
package bcbn_exec_pkg;
   // Execution phase, one-hot
   typedef enum logic [1:0] {
      PH_EXEC  = 2'b01,
      PH_FLUSH = 2'b10
   } phase_t;
endpackage

// ===== tb/tb_top.sv
// Self-checking bench for the bit-clear / branch-if-negative unit.
// Assumes the unit is compiled first; the bench models the register file.
`timescale 1ns/1ps
module tb_top;
   // ==========================================
   // Stimulus, model and unit ports
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   logic        instrValid = 1'b0;
   logic [15:0] instrWord = 16'h0000;
   logic [20:0] instrAddr = 21'h000000;
   logic [7:0]  statusIn = 8'h00;
   logic [3:0]  bankSelectPointer = 4'h0;
   logic [7:0]  salt = 8'h00;          // Varies file contents per instruction
   logic [11:0] rdAddr, wrAddr_q;
   logic [7:0]  rdData, wrData_q;
   logic [20:0] pcNext_q;
   logic        wrEn_q, pcLoad_q, flush_q, busy_q;
   logic [31:0] rng = 32'hf4ab2f7e;    // Fixed seed
   logic [33:0] expQ[$];               // Flag, value, address
   logic        skipNext = 1'b0;       // Slot after a taken branch is dropped
   int          err_total = 0;
   int          cmp_count = 0;
   int          cycles = 0;

   always #2 clock = ~clock;
   // File contents depend on the whole address, so a wrong bank shows up
   assign rdData = rdAddr[7:0] ^ {rdAddr[11:8], rdAddr[11:8]} ^ salt;

   bcbn_exec dut_u (.clock(clock), .rstn(rstn), .instrValid(instrValid),
      .instrWord(instrWord), .instrAddr(instrAddr), .statusIn(statusIn),
      .bankSelectPointer(bankSelectPointer), .rdAddr(rdAddr), .rdData(rdData),
      .wrEn_q(wrEn_q), .wrAddr_q(wrAddr_q), .wrData_q(wrData_q), .pcLoad_q(pcLoad_q),
      .pcNext_q(pcNext_q), .flush_q(flush_q), .busy_q(busy_q));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Drives one slot at the falling edge and notes what must follow
   task automatic issue(input logic v, input logic [15:0] w, input logic [7:0] st,
                        input logic [7:0] sl);
      logic [11:0] a;
      logic [7:0]  d;
      logic [20:0] ad;
      logic        tk;
      @(negedge clock);
      rng = xs(rng);
      ad = {rng[20:1], 1'b0};
      instrValid <= v;
      instrWord <= w;
      statusIn <= st;
      salt <= sl;
      instrAddr <= ad;
      bankSelectPointer <= rng[27:24];
      a = w[8] ? {rng[27:24], w[7:0]} : {(w[7:0] < 8'h60) ? 4'h0 : 4'hf, w[7:0]};
      d = (w[7:0] ^ {a[11:8], a[11:8]} ^ sl) & ~(8'h01 << w[11:9]);
      tk = v && !skipNext && w[15:8] == 8'he6 && st[4];
      if (v && !skipNext && w[15:12] == 4'h9) begin
         expQ.push_back({1'b0, 13'h0000, d, a});
      end else if (tk) begin
         expQ.push_back({1'b1, ad + 21'h000002 + {{12{w[7]}}, w[7:0], 1'b0}, 12'h000});
      end
      skipNext = tk;
   endtask

   // Watches the registered outputs and pairs them with the oldest note
   always @(negedge clock) begin
      logic [33:0] e;
      e = 34'h0;
      cycles++;
      if (cycles > 3000) begin
         err_total++;
         stop_test();
      end else begin
         if (wrEn_q === 1'b1 || pcLoad_q === 1'b1) begin
            if (expQ.size() == 0) begin
               check(34'h1, 34'h0);
            end else begin
               e = expQ.pop_front();
               check(pcLoad_q ? {1'b1, pcNext_q, 12'h000} : {14'h0000, wrData_q, wrAddr_q},
                     e);
            end
         end
         // Flush and busy stand exactly in the cycle that answers a taken branch
         check({32'h0, flush_q, busy_q}, {32'h0, e[33], e[33]});
      end
   end

   initial begin
      repeat (12) @(posedge clock);
      @(negedge clock);
      rstn <= 1'b1;
      for (int b = 0; b < 8; b++) begin
         issue(1'b1, {4'h9, 3'(b), 1'b0, 8'h20}, 8'h00, 8'he7);
         issue(1'b1, {4'h9, 3'(b), 1'b0, 8'h9c}, 8'hff, 8'h3c);
         issue(1'b1, {4'h9, 3'(b), 1'b1, 8'(b * 37)}, 8'h10, 8'h5a);
      end
      $display("Test bit clear table done");
      issue(1'b1, 16'he680, 8'h10, 8'h00);
      issue(1'b1, 16'h9720, 8'h00, 8'h00);
      issue(1'b1, 16'he67f, 8'hef, 8'h00);
      issue(1'b1, 16'he67f, 8'h10, 8'h00);
      issue(1'b0, 16'h9000, 8'h00, 8'h00);
      $display("Test branch edges done");
      repeat (400) begin
         rng = xs(rng);
         issue(rng[31:29] != 3'h0, rng[28] ? {4'h9, rng[11:0]} :
               (rng[27] ? {8'he6, rng[7:0]} : {4'h1, rng[11:0]}), rng[19:12], rng[26:19]);
      end
      issue(1'b0, 16'h0000, 8'h00, 8'h00);
      repeat (4) @(negedge clock);
      check(34'(expQ.size()), 34'h0);
      $display("Test random mix done");
      // Mid-run reset must clear every registered output at once
      @(negedge clock);
      rstn <= 1'b0;
      @(negedge clock);
      check({13'h0000, pcNext_q}, 34'h0);
      check({10'h000, flush_q, busy_q, wrEn_q, pcLoad_q, wrData_q, wrAddr_q},
            34'h0);
      @(negedge clock);
      rstn <= 1'b1;
      // After release: taken branch, a refused slot, then a banked clear
      issue(1'b1, 16'he6f0, 8'h90, 8'h00);
      issue(1'b1, 16'h9e33, 8'h00, 8'h00);
      issue(1'b1, 16'h9b71, 8'h00, 8'h11);
      issue(1'b0, 16'h0000, 8'h00, 8'h00);
      repeat (3) @(negedge clock);
      check(34'(expQ.size()), 34'h0);
      $display("Test mid-run reset done");
      stop_test();
   end
endmodule // tb_top
